// *** rsc_pkg.sv ***
package rsc_pkg;

    // register byte offsets on the register port
    localparam logic [7:0] ADDR_TIME_VALID   = 8'h1D;
    localparam logic [7:0] ADDR_HEALTH_FLAGS = 8'h1E;
    localparam logic [7:0] ADDR_CORR_ENABLE  = 8'h1F;
    localparam logic [7:0] ADDR_CORR_AMOUNT  = 8'h20;
    localparam logic [7:0] ADDR_SLOW_CLOCK_OUTPUT_CONTROL_CTRL  = 8'h21;

    // field positions
    localparam int VALID_BIT   = 7;
    localparam int OSC_BIT     = 0;
    localparam int BKUP_BIT    = 1;
    localparam int POR_BIT     = 2;
    localparam int SCR_LSB     = 3;
    localparam int SCR_MSB     = 7;
    localparam int ENA_BIT     = 0;
    localparam int AMT_MSB     = 5;
    localparam int SIGN_BIT    = 6;
    localparam int MASK_BIT    = 0;

    localparam int SCR_W       = SCR_MSB - SCR_LSB + 1;
    localparam int TRIM_W      = AMT_MSB + 1;

    // reset values
    localparam logic [7:0] RST_TIME_VALID   = 8'h00;
    localparam logic [7:0] RST_HEALTH_FLAGS = 8'h05;
    localparam logic [7:0] RST_CORR_ENABLE  = 8'h00;
    localparam logic [7:0] RST_CORR_AMOUNT  = 8'h00;
    localparam logic [7:0] RST_SLOW_CLOCK_OUTPUT_CONTROL_CTRL  = 8'h00;
    localparam logic [7:0] READ_UNMAPPED    = 8'h00;

    function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] target);
        addr_is = (addr == target);
    endfunction : addr_is

endpackage : rsc_pkg

// *** rsc_rate_trim.sv ***
`timescale 1ns/1ps
module rsc_rate_trim
    import rsc_pkg::*;
#(
    parameter int W = TRIM_W
) (
    input  wire logic         clk,          // system clock
    input  wire logic         rst,          // synchronous reset, active high
    input  wire logic         sec_tick,     // one-second pulse from the time base
    input  wire logic         enable,       // trimming on
    input  wire logic [W-1:0] amount,       // seconds corrected per period
    input  wire logic         subtract,     // 1 removes seconds, 0 adds
    output logic              sec_advance,  // advance the seconds count
    output logic              sec_double    // advance by one extra second
);

    logic [W-1:0] period_cnt;
    wire logic    correct_now = enable && (period_cnt < amount);

    always_ff @(posedge clk) begin
        if (rst) begin
            period_cnt  <= '0;
            sec_advance <= 1'b0;
            sec_double  <= 1'b0;
        end else begin
            // period_cnt wraps after 2**W seconds, one trim period
            if (sec_tick) begin
                period_cnt <= period_cnt + 1'b1;
            end
            sec_advance <= sec_tick && !(correct_now && subtract);
            sec_double  <= sec_tick && correct_now && !subtract;
        end
    end

    property p_trim_off;
        @(posedge clk) disable iff (rst)
        sec_tick && !enable |=> sec_advance && !sec_double;
    endproperty
    a_trim_off: assert property (p_trim_off) else $error("trim acted while disabled");

    property p_trim_sub;
        @(posedge clk) disable iff (rst)
        sec_tick && enable && subtract && (period_cnt < amount) |=> !sec_advance && !sec_double;
    endproperty
    a_trim_sub: assert property (p_trim_sub) else $error("subtract did not drop tick");

    property p_trim_add;
        @(posedge clk) disable iff (rst)
        sec_tick && enable && !subtract && (period_cnt < amount) |=> sec_advance && sec_double;
    endproperty
    a_trim_add: assert property (p_trim_add) else $error("add did not double tick");

    property p_trim_past;
        @(posedge clk) disable iff (rst)
        sec_tick && (period_cnt >= amount) |=> sec_advance && !sec_double;
    endproperty
    a_trim_past: assert property (p_trim_past) else $error("correction past amount");

    property p_no_tick_quiet;
        @(posedge clk) disable iff (rst)
        !sec_tick |=> !sec_advance && !sec_double;
    endproperty
    a_no_tick_quiet: assert property (p_no_tick_quiet) else $error("advance without tick");

    c_trim_add: cover property (@(posedge clk) disable iff (rst) sec_double);
    c_trim_sub: cover property (@(posedge clk) disable iff (rst)
        sec_tick && enable && subtract && (period_cnt < amount));

endmodule : rsc_rate_trim

// *** rsc_slow_clock_output_control_gate.sv ***
`timescale 1ns/1ps
module rsc_slow_clock_output_control_gate (
    input  wire logic clk,           // system clock
    input  wire logic rst,           // synchronous reset, active high
    input  wire logic slow_clk_in,   // 32 kHz clock level, sampled
    input  wire logic mask,          // 1 disables the output
    output logic      slow_clk_out   // gated 32 kHz clock
);

    always_ff @(posedge clk) begin
        if (rst) begin
            slow_clk_out <= 1'b0;
        end else begin
            slow_clk_out <= slow_clk_in && !mask;
        end
    end

    property p_masked_low;
        @(posedge clk) disable iff (rst)
        mask |=> !slow_clk_out;
    endproperty
    a_masked_low: assert property (p_masked_low) else $error("masked clock output active");

    property p_passes;
        @(posedge clk) disable iff (rst)
        !mask |=> slow_clk_out == $past(slow_clk_in);
    endproperty
    a_passes: assert property (p_passes) else $error("clock output not following input");

endmodule : rsc_slow_clock_output_control_gate

// *** rsc_status_trim_top.sv ***
`timescale 1ns/1ps
// Operation
// - time-valid bit reads 0 once time and calendar registers are reset; a same-cycle read of the validity register sets it instead.
// - only a read of the validity register sets time-valid; writes never do.
// - flags bit 0 shows clock source: 0 crystal, 1 internal RC.
// - flags bit 1 becomes 1 when coin cell drops below threshold.
// - flags bit 2 reads 1 after a power-on reset, 0 otherwise.
// - flags bits 7:3 are scratch storage, cleared by power-on reset.
// - flags reset to 0x05, validity register resets to 0x00.
// - trim-enable bit 0 turns rate correction off or on.
// - six-bit amount gives seconds corrected per 64-second period.
// - trim bit 6 picks direction: 0 adds seconds, 1 subtracts.
// - clock-output bit 0: 0 drives 32 kHz out, 1 masks; resets 0.
module rsc_status_trim_top
    import rsc_pkg::*;
(
    input  wire logic       CLK_SYS,          // 40 MHz system clock
    input  wire logic       SYS_RST,          // power-on reset, synchronous, active high
    input  wire logic [7:0] REG_ADDR,         // register address
    input  wire logic [7:0] REG_WDATA,        // write data
    input  wire logic       REG_WR,           // write strobe
    input  wire logic       REG_RD,           // read strobe
    output logic      [7:0] REG_RDATA,        // read data, one cycle after strobe
    output logic            REG_RVALID,       // read data valid pulse
    input  wire logic       OSC_RC_ACTIVE,    // 1 while internal RC oscillator runs
    input  wire logic       COIN_LOW,         // coin cell below low-voltage threshold
    input  wire logic       TIME_REGS_CLEAR,  // time and calendar registers reset
    input  wire logic       SEC_TICK,         // one-second pulse from the time base
    input  wire logic       SLOW_CLK_IN,      // 32 kHz clock level
    output logic            SEC_ADVANCE,      // advance seconds count
    output logic            SEC_DOUBLE,       // advance one extra second
    output logic            SLOW_CLK_OUT      // gated 32 kHz output
);

    logic             time_valid_bit;
    logic             osc_source_flag;
    logic             backup_cell_low_flag;
    logic             por_flag;
    logic [SCR_W-1:0] scratch;
    logic             rate_correction_enable_bit;
    logic [TRIM_W-1:0] correction_seconds;
    logic             correction_sign;
    logic             slow_clock_output_mask;
    logic             coin_low_d;

    // address decode
    wire logic hit_valid  = addr_is(REG_ADDR, ADDR_TIME_VALID);
    wire logic hit_flags  = addr_is(REG_ADDR, ADDR_HEALTH_FLAGS);
    wire logic hit_enable = addr_is(REG_ADDR, ADDR_CORR_ENABLE);
    wire logic hit_amount = addr_is(REG_ADDR, ADDR_CORR_AMOUNT);
    wire logic hit_slow_clock_output_control = addr_is(REG_ADDR, ADDR_SLOW_CLOCK_OUTPUT_CONTROL_CTRL);

    wire logic rd_valid   = REG_RD && hit_valid;
    wire logic wr_flags   = REG_WR && hit_flags;
    wire logic wr_enable  = REG_WR && hit_enable;
    wire logic wr_amount  = REG_WR && hit_amount;
    wire logic wr_slow_clock_output_control  = REG_WR && hit_slow_clock_output_control;

    wire logic coin_fall  = COIN_LOW && !coin_low_d;
    wire logic clr_bkup   = wr_flags && !REG_WDATA[BKUP_BIT];
    wire logic clr_por    = wr_flags && !REG_WDATA[POR_BIT];

    // a read sets the valid bit and wins over a simultaneous clear
    wire logic next_time_valid = rd_valid ? 1'b1 :
                                 TIME_REGS_CLEAR ? 1'b0 : time_valid_bit;
    wire logic next_backup     = coin_fall ? 1'b1 :
                                 clr_bkup ? 1'b0 : backup_cell_low_flag;
    wire logic next_por        = clr_por ? 1'b0 : por_flag;

    // read values; reserved bits are constant zero
    wire logic [7:0] valid_value  = 8'(time_valid_bit) << VALID_BIT;
    wire logic [7:0] flags_value  = {scratch, por_flag, backup_cell_low_flag,
                                     osc_source_flag};
    wire logic [7:0] enable_value = 8'(rate_correction_enable_bit) << ENA_BIT;
    wire logic [7:0] amount_value = (8'(correction_sign) << SIGN_BIT)
                                  | 8'(correction_seconds);
    wire logic [7:0] slow_clock_output_control_value = 8'(slow_clock_output_mask) << MASK_BIT;

    wire logic [7:0] next_rdata = hit_valid  ? valid_value  :
                                  hit_flags  ? flags_value  :
                                  hit_enable ? enable_value :
                                  hit_amount ? amount_value :
                                  hit_slow_clock_output_control ? slow_clock_output_control_value : READ_UNMAPPED;

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            time_valid_bit       <= RST_TIME_VALID[VALID_BIT];
            osc_source_flag      <= RST_HEALTH_FLAGS[OSC_BIT];
            backup_cell_low_flag <= RST_HEALTH_FLAGS[BKUP_BIT];
            por_flag             <= RST_HEALTH_FLAGS[POR_BIT];
            scratch              <= RST_HEALTH_FLAGS[SCR_MSB:SCR_LSB];
            coin_low_d           <= 1'b0;
        end else begin
            time_valid_bit       <= next_time_valid;
            osc_source_flag      <= OSC_RC_ACTIVE;
            backup_cell_low_flag <= next_backup;
            por_flag             <= next_por;
            coin_low_d           <= COIN_LOW;
            if (wr_flags) begin
                scratch <= REG_WDATA[SCR_MSB:SCR_LSB];
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            rate_correction_enable_bit <= RST_CORR_ENABLE[ENA_BIT];
            correction_seconds         <= RST_CORR_AMOUNT[AMT_MSB:0];
            correction_sign            <= RST_CORR_AMOUNT[SIGN_BIT];
            slow_clock_output_mask     <= RST_SLOW_CLOCK_OUTPUT_CONTROL_CTRL[MASK_BIT];
        end else begin
            if (wr_enable) begin
                rate_correction_enable_bit <= REG_WDATA[ENA_BIT];
            end
            if (wr_amount) begin
                correction_seconds <= REG_WDATA[AMT_MSB:0];
                correction_sign    <= REG_WDATA[SIGN_BIT];
            end
            if (wr_slow_clock_output_control) begin
                slow_clock_output_mask <= REG_WDATA[MASK_BIT];
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            REG_RDATA  <= READ_UNMAPPED;
            REG_RVALID <= 1'b0;
        end else begin
            REG_RDATA  <= REG_RD ? next_rdata : REG_RDATA;
            REG_RVALID <= REG_RD;
        end
    end

    rsc_rate_trim #(
        .W(TRIM_W)
    ) u_trim (
        .clk         (CLK_SYS),
        .rst         (SYS_RST),
        .sec_tick    (SEC_TICK),
        .enable      (rate_correction_enable_bit),
        .amount      (correction_seconds),
        .subtract    (correction_sign),
        .sec_advance (SEC_ADVANCE),
        .sec_double  (SEC_DOUBLE)
    );

    rsc_slow_clock_output_control_gate u_slow_clock_output_control (
        .clk          (CLK_SYS),
        .rst          (SYS_RST),
        .slow_clk_in  (SLOW_CLK_IN),
        .mask         (slow_clock_output_mask),
        .slow_clk_out (SLOW_CLK_OUT)
    );

    property p_valid_cleared;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        TIME_REGS_CLEAR && !rd_valid |=> !time_valid_bit;
    endproperty
    a_valid_cleared: assert property (p_valid_cleared) else $error("valid bit not cleared");

    property p_valid_only_by_read;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        $rose(time_valid_bit) |-> $past(REG_RD) && $past(REG_ADDR) == ADDR_TIME_VALID;
    endproperty
    a_valid_only_by_read: assert property (p_valid_only_by_read) else $error("valid set without read");

    property p_valid_read_sets;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        rd_valid |=> REG_RVALID && time_valid_bit ##1 (time_valid_bit || $past(TIME_REGS_CLEAR));
    endproperty
    a_valid_read_sets: assert property (p_valid_read_sets) else $error("read did not set valid");

    property p_osc_readback;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        !$past(SYS_RST) && REG_RD && hit_flags |=> REG_RDATA[OSC_BIT] == $past(OSC_RC_ACTIVE, 2);
    endproperty
    a_osc_readback: assert property (p_osc_readback) else $error("clock source flag wrong");

    property p_bkup_set;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        !$past(SYS_RST) && $rose(COIN_LOW) |=> backup_cell_low_flag [*2] or
            (backup_cell_low_flag ##1 $past(clr_bkup));
    endproperty
    a_bkup_set: assert property (p_bkup_set) else $error("coin cell flag not set");

    property p_bkup_hold;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        backup_cell_low_flag && !clr_bkup |=> backup_cell_low_flag;
    endproperty
    a_bkup_hold: assert property (p_bkup_hold) else $error("coin cell flag lost");

    property p_por_no_set;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        !por_flag |=> !por_flag;
    endproperty
    a_por_no_set: assert property (p_por_no_set) else $error("reset flag set without reset");

    property p_scratch_rw;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        wr_flags ##1 !REG_WR ##1 (REG_RD && hit_flags && !REG_WR) |=>
            REG_RDATA[SCR_MSB:SCR_LSB] == $past(REG_WDATA[SCR_MSB:SCR_LSB], 3);
    endproperty
    a_scratch_rw: assert property (p_scratch_rw) else $error("scratch readback wrong");

    property p_reset_values;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        $fell(SYS_RST) |-> flags_value == RST_HEALTH_FLAGS && valid_value == RST_TIME_VALID
            && slow_clock_output_control_value == RST_SLOW_CLOCK_OUTPUT_CONTROL_CTRL;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("reset value wrong");

    property p_reserved_zero;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        REG_RD && (hit_enable || hit_slow_clock_output_control) |=> REG_RDATA[7:1] == 7'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero");

    property p_valid_reserved;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        REG_RD && hit_valid |=> REG_RDATA[VALID_BIT-1:0] == 7'h00;
    endproperty
    a_valid_reserved: assert property (p_valid_reserved) else $error("valid reserved set");

    property p_amount_reserved;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        REG_RD && hit_amount |=> !REG_RDATA[SIGN_BIT+1];
    endproperty
    a_amount_reserved: assert property (p_amount_reserved) else $error("trim bit 7 set");

    property p_unmapped_zero;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        REG_RD && !(hit_valid || hit_flags || hit_enable || hit_amount || hit_slow_clock_output_control)
            |=> REG_RDATA == READ_UNMAPPED;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read nonzero");

    property p_write_no_valid;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        REG_WR && hit_valid && !REG_RD && !time_valid_bit |=> !time_valid_bit;
    endproperty
    a_write_no_valid: assert property (p_write_no_valid) else $error("write set valid");

    property p_osc_follow;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        !$past(SYS_RST) |-> osc_source_flag == $past(OSC_RC_ACTIVE);
    endproperty
    a_osc_follow: assert property (p_osc_follow) else $error("source flag not following");

    property p_bkup_clear;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        clr_bkup && !coin_fall |=> !backup_cell_low_flag;
    endproperty
    a_bkup_clear: assert property (p_bkup_clear) else $error("coin cell flag not cleared");

    property p_por_clear;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        clr_por |=> !por_flag;
    endproperty
    a_por_clear: assert property (p_por_clear) else $error("reset flag not cleared");

    property p_scratch_hold;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        !wr_flags |=> $stable(scratch);
    endproperty
    a_scratch_hold: assert property (p_scratch_hold) else $error("scratch changed");

    property p_enable_rw;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        wr_enable |=> rate_correction_enable_bit == $past(REG_WDATA[ENA_BIT]);
    endproperty
    a_enable_rw: assert property (p_enable_rw) else $error("trim enable not stored");

    property p_amount_rw;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        wr_amount |=> correction_seconds == $past(REG_WDATA[AMT_MSB:0])
            && correction_sign == $past(REG_WDATA[SIGN_BIT]);
    endproperty
    a_amount_rw: assert property (p_amount_rw) else $error("trim amount not stored");

    property p_mask_rw;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        wr_slow_clock_output_control |=> slow_clock_output_mask == $past(REG_WDATA[MASK_BIT]);
    endproperty
    a_mask_rw: assert property (p_mask_rw) else $error("output mask not stored");

    property p_trim_reset;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        $fell(SYS_RST) |-> enable_value == RST_CORR_ENABLE && amount_value == RST_CORR_AMOUNT;
    endproperty
    a_trim_reset: assert property (p_trim_reset) else $error("trim reset value wrong");

    property p_rvalid_pulse;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        !$past(SYS_RST) |-> REG_RVALID == $past(REG_RD);
    endproperty
    a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read valid pulse wrong");

    property p_rdata_hold;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        !REG_RD |=> $stable(REG_RDATA);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without read");

    c_valid_set: cover property (@(posedge CLK_SYS) disable iff (SYS_RST) $rose(time_valid_bit));
    c_bkup_set:  cover property (@(posedge CLK_SYS) disable iff (SYS_RST) $rose(backup_cell_low_flag));
    c_por_clear: cover property (@(posedge CLK_SYS) disable iff (SYS_RST) $fell(por_flag));

endmodule : rsc_status_trim_top

// *** rsc_ctrl_model.sv ***
`timescale 1ns/1ps
module rsc_ctrl_model
    import rsc_pkg::*;
(
    input  wire logic       clk,     // system clock
    input  wire logic [7:0] rdata,   // read data from the device
    input  wire logic       rvalid,  // read data valid pulse
    output logic      [7:0] addr,    // register address
    output logic      [7:0] wdata,   // write data
    output logic            wr,      // write strobe
    output logic            rd       // read strobe
);
    logic [7:0] last_addr = 8'h00;
    logic [7:0] last_wdata = 8'h00;

    initial begin
        addr  = 8'h00;
        wdata = 8'h00;
        wr    = 1'b0;
        rd    = 1'b0;
    end

    // released bus shows the inverse, never the stale value
    task automatic release_bus();
        addr  = ~last_addr;
        wdata = ~last_wdata;
        wr    = 1'b0;
        rd    = 1'b0;
        @(posedge clk);
        #1;
    endtask : release_bus

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr       = a;
        wdata      = d;
        wr         = 1'b1;
        last_addr  = a;
        last_wdata = d;
        @(posedge clk);
        #1;
        release_bus();
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
        addr      = a;
        rd        = 1'b1;
        last_addr = a;
        @(posedge clk);
        #1;
        d = rdata;
        v = rvalid;
        release_bus();
    endtask : rd_reg

    task automatic mark_time_valid(output logic [7:0] d, output logic v);
        rd_reg(ADDR_TIME_VALID, d, v);
    endtask : mark_time_valid

    task automatic clear_coin_flag(input logic [7:0] keep);
        wr_reg(ADDR_HEALTH_FLAGS, keep & 8'hFD);
    endtask : clear_coin_flag
endmodule : rsc_ctrl_model

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
    import rsc_pkg::*;
    logic       clk_sys = 1'b0;
    logic       sys_rst, osc_rc, coin_low, time_clr, sec_tick, slow_in;
    wire  [7:0] reg_addr, reg_wdata, reg_rdata;
    wire        reg_wr, reg_rd, reg_rvalid, sec_adv, sec_dbl, slow_out;
    integer     seed = 34251;
    int         n_errors = 0;
    int         num_checks = 0;
    int         ticks = 0;
    logic [7:0] d, s;
    logic       v, en, sub;
    logic [5:0] amt;

    always #12.5 clk_sys = ~clk_sys;

    rsc_status_trim_top u_rsc_status_trim_top (
        .CLK_SYS(clk_sys), .SYS_RST(sys_rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid),
        .OSC_RC_ACTIVE(osc_rc), .COIN_LOW(coin_low), .TIME_REGS_CLEAR(time_clr),
        .SEC_TICK(sec_tick), .SLOW_CLK_IN(slow_in), .SEC_ADVANCE(sec_adv),
        .SEC_DOUBLE(sec_dbl), .SLOW_CLK_OUT(slow_out)
    );

    rsc_ctrl_model u_rsc_ctrl_model (
        .clk(clk_sys), .rdata(reg_rdata), .rvalid(reg_rvalid), .addr(reg_addr),
        .wdata(reg_wdata), .wr(reg_wr), .rd(reg_rd)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] rv;
        logic       ok;
        u_rsc_ctrl_model.rd_reg(a, rv, ok);
        check({7'h00, ok}, 8'h01, "read valid");
        check(rv, exp, "read data");
    endtask : rd_chk

    task automatic do_reset();
        sys_rst = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        sys_rst = 1'b0;
        ticks   = 0;
    endtask : do_reset

    // {double, advance} for tick k of the 64-tick period
    function automatic logic [1:0] exp_trim(input int k, input logic e, input logic [5:0] n,
                                            input logic sb);
        logic corr;
        corr     = e && (k < n);
        exp_trim = {corr && !sb, !(corr && sb)};
    endfunction : exp_trim

    task automatic tick();
        sec_tick = 1'b1;
        @(posedge clk_sys);
        #1;
        sec_tick = 1'b0;
        check({6'h00, sec_dbl, sec_adv}, {6'h00, exp_trim(ticks % 64, en, amt, sub)}, "trim");
        ticks++;
        @(posedge clk_sys);
        #1;
        check({6'h00, sec_dbl, sec_adv}, 8'h00, "idle advance");
    endtask : tick

    initial begin
        repeat (60000) @(posedge clk_sys);
        n_errors++;
        $display("mismatch at %0t: run did not finish", $time);
        give_verdict();
    end

    initial begin
        {osc_rc, coin_low, time_clr, sec_tick, slow_in} = 5'b10000;
        do_reset();
        rd_chk(ADDR_HEALTH_FLAGS, 8'h05);
        rd_chk(ADDR_TIME_VALID, 8'h00);
        rd_chk(ADDR_TIME_VALID, 8'h80);
        rd_chk(ADDR_CORR_ENABLE, 8'h00);
        rd_chk(ADDR_CORR_AMOUNT, 8'h00);
        rd_chk(ADDR_SLOW_CLOCK_OUTPUT_CONTROL_CTRL, 8'h00);
        u_rsc_ctrl_model.wr_reg(8'h22, 8'hFF);
        rd_chk(8'h22, 8'h00);
        time_clr = 1'b1;
        @(posedge clk_sys);
        #1;
        time_clr = 1'b0;
        u_rsc_ctrl_model.wr_reg(ADDR_TIME_VALID, 8'hFF);
        u_rsc_ctrl_model.mark_time_valid(d, v);
        check(d, 8'h00, "time valid after clear");
        rd_chk(ADDR_TIME_VALID, 8'h80);
        osc_rc = 1'b0;
        @(posedge clk_sys);
        #1;
        rd_chk(ADDR_HEALTH_FLAGS, 8'h04);
        coin_low = 1'b1;
        @(posedge clk_sys);
        #1;
        rd_chk(ADDR_HEALTH_FLAGS, 8'h06);
        u_rsc_ctrl_model.clear_coin_flag(8'h07);
        rd_chk(ADDR_HEALTH_FLAGS, 8'h04);
        u_rsc_ctrl_model.wr_reg(ADDR_HEALTH_FLAGS, 8'h03);
        rd_chk(ADDR_HEALTH_FLAGS, 8'h00);
        for (int i = 0; i < 4; i++) begin
            s = 8'($random(seed));
            u_rsc_ctrl_model.wr_reg(ADDR_HEALTH_FLAGS, {s[7:3], 3'b111});
            rd_chk(ADDR_HEALTH_FLAGS, {s[7:3], 3'b000});
        end
        for (int c = 0; c < 6; c++) begin
            s   = 8'($random(seed));
            en  = (c == 0) ? 1'b0 : ((c < 4) ? 1'b1 : s[0]);
            amt = (c == 1) ? 6'h00 : ((c < 4) ? 6'h3F : s[6:1]);
            sub = (c == 3) ? 1'b1 : ((c < 4) ? 1'b0 : s[7]);
            u_rsc_ctrl_model.wr_reg(ADDR_CORR_ENABLE, {s[7:1], en});
            rd_chk(ADDR_CORR_ENABLE, {7'h00, en});
            u_rsc_ctrl_model.wr_reg(ADDR_CORR_AMOUNT, {s[0], sub, amt});
            rd_chk(ADDR_CORR_AMOUNT, {1'b0, sub, amt});
            repeat (64) tick();
        end
        for (int m = 0; m < 2; m++) begin
            s = 8'($random(seed));
            u_rsc_ctrl_model.wr_reg(ADDR_SLOW_CLOCK_OUTPUT_CONTROL_CTRL, {s[7:1], m[0]});
            rd_chk(ADDR_SLOW_CLOCK_OUTPUT_CONTROL_CTRL, {7'h00, m[0]});
            for (int i = 0; i < 20; i++) begin
                slow_in = 1'($random(seed));
                @(posedge clk_sys);
                #1;
                check({7'h00, slow_out}, {7'h00, slow_in & ~m[0]}, "clock out");
            end
        end
        osc_rc = 1'b1;
        do_reset();
        rd_chk(ADDR_HEALTH_FLAGS, 8'h05);
        rd_chk(ADDR_SLOW_CLOCK_OUTPUT_CONTROL_CTRL, 8'h00);
        rd_chk(ADDR_TIME_VALID, 8'h00);
        give_verdict();
    end
endmodule : tb
